/* hw/gpio_pin_config_defs.vh */
`ifndef GPIO_PIN_CONFIG_DEFS_VH
`define GPIO_PIN_CONFIG_DEFS_VH

// Pin counts of the two register halves.
`define LOW_PIN_COUNT 6
`define HIGH_PIN_COUNT 5
`define PIN_COUNT 11

// Register offsets.
`define ADDR_STATUS 8'h01
`define ADDR_FLAG_HIGH 8'h14
`define ADDR_POLARITY_HIGH 8'h1c
`define ADDR_QUEUE_EN_HIGH 8'h1e
`define ADDR_IRQ_EN_HIGH 8'h20
`define ADDR_DEB_LOW 8'h21
`define ADDR_DEB_HIGH 8'h22
`define ADDR_LEVEL_LOW 8'h23
`define ADDR_LEVEL_HIGH 8'h24
`define ADDR_MODE_LOW 8'h25
`define ADDR_MODE_HIGH 8'h26
`define ADDR_OE_LOW 8'h27
`define ADDR_OE_HIGH 8'h28

// Field positions and masks.
`define STATUS_SUMMARY_BIT 1
`define MASK_LOW 8'h3f
`define MASK_HIGH 8'h1f

// Reset values.
`define REG_RESET_LOW 6'h00
`define REG_RESET_HIGH 5'h00
`define READ_UNMAPPED 8'h00

// Timing.
`define CLK_PERIOD_NS 4
`define DEBOUNCE_TIME_NS 40
`define DEBOUNCE_CYCLES ((`DEBOUNCE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DEBOUNCE_CNT_W 8

`endif

/* hw/gpio_input_filter.v */
`timescale 1ns/10ps
module gpio_input_filter #(
  parameter CYCLES = 10,
  parameter CNT_W = 8
) (
  // Clock and reset.
  input wire ref_clk_in,
  input wire sys_rst_in,
  // Sampled pin and control.
  input wire raw_in,
  input wire bypass_in,
  // Filtered level.
  output wire level_out
);

  localparam integer LIMIT_INT = CYCLES - 1;
  localparam [CNT_W-1:0] LIMIT = LIMIT_INT[CNT_W-1:0];
  localparam [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};

  reg level_q;
  reg level_d;
  reg [CNT_W-1:0] cnt_q;
  reg [CNT_W-1:0] cnt_d;

  ////////////////////////////////////////////////////////////////////////////
  // A new level is taken once it has stood for the full count, or at once when bypassed.
  always @* begin
    level_d = level_q;
    cnt_d = {CNT_W{1'b0}};
    if (bypass_in) begin
      level_d = raw_in;
    end else if (raw_in != level_q) begin
      if (cnt_q >= LIMIT) begin
        level_d = raw_in;
      end else begin
        cnt_d = cnt_q + CNT_ONE;
      end
    end
  end

  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      level_q <= 1'b0;
      cnt_q <= {CNT_W{1'b0}};
    end else begin
      level_q <= level_d;
      cnt_q <= cnt_d;
    end
  end

  assign level_out = level_q;

endmodule

/* hw/gpio_pin_config_bank.v */
// How it works
// R1 - An upper input whose irq enable bit is set, whose queue enable bit is clear, whose flag is latched and whose condition holds drives status bit 1.
// R2 - An upper input whose irq enable bit is clear never contributes to the summary status bit.
// R3 - Bits 0 to 5 of offset 0x21 bypass the debounce filter of inputs 1 to 6 when set.
// R4 - Bits 0 to 4 of offset 0x22 bypass the debounce filter of inputs 7 to 11 when set.
// R5 - Bits 0 to 5 of offset 0x23 give the driven level of outputs 1 to 6.
// R6 - Bits 0 to 4 of offset 0x24 give the driven level of outputs 7 to 11.
// R7 - Bits 0 to 5 of offset 0x25 choose push-pull at 0 or open-drain at 1 for outputs 1 to 6.
// R8 - Bits 0 to 4 of offset 0x26 choose push-pull at 0 or open-drain at 1 for outputs 7 to 11.
// R9 - Bits 0 to 5 of offset 0x27 enable the output driver of pins 1 to 6.
// R10 - The flag of an upper input whose queue enable bit is clear latches while its filtered pin equals its polarity bit, low for 0 and high for 1.
// R11 - An input set to report into the event queue raises the event interrupt and never the summary bit.
// R12 - Reserved upper bits of every register read as zero and ignore writes.
// R13 - Level and drive style reach a pin only while its output enable bit is set.
`timescale 1ns/10ps
`include "gpio_pin_config_defs.vh"
module gpio_pin_config_bank #(
  parameter DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES,
  parameter DEBOUNCE_CNT_W = `DEBOUNCE_CNT_W
) (
  // Clock and reset.
  input wire ref_clk_in,
  input wire sys_rst_in,
  // Register port behind the serial interface.
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output wire [7:0] reg_rdata_out,
  output wire reg_rvalid_out,
  // Pins.
  input wire [10:0] pin_in,
  output wire [10:0] pin_out,
  output wire [10:0] pin_oe_out,
  // Filtered input levels.
  output wire [10:0] pin_level_out,
  // Interrupt indications.
  output wire input_irq_summary_out,
  output wire [4:0] queue_event_out,
  output wire event_irq_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers.
  reg [5:0] deb_low_q;
  reg [4:0] deb_high_q;
  reg [5:0] level_low_q;
  reg [4:0] level_high_q;
  reg [5:0] mode_low_q;
  reg [4:0] mode_high_q;
  reg [5:0] oe_low_q;
  reg [4:0] oe_high_q;
  reg [4:0] polarity_high_q;
  reg [4:0] queue_en_high_q;
  reg [4:0] irq_en_high_q;

  // Input state.
  reg [10:0] sync1_q;
  reg [10:0] sync2_q;
  wire [10:0] filt_w;
  reg [4:0] filt_prev_q;
  reg [4:0] flag_high_q;
  reg [4:0] flag_high_d;
  reg summary_q;
  reg [4:0] queue_event_q;
  reg event_irq_q;

  // Output and read state.
  reg [10:0] pin_out_q;
  reg [10:0] pin_oe_q;
  reg [10:0] pin_level_q;
  reg [7:0] rdata_q;
  reg [7:0] rdata_d;
  reg rvalid_q;

  // Combined views.
  wire [10:0] bypass_all;
  wire [10:0] level_all;
  wire [10:0] mode_all;
  wire [10:0] oe_all;
  wire [4:0] cond_high;
  wire [4:0] flag_set;
  wire [4:0] flag_clr;
  wire [4:0] summary_terms;
  wire [4:0] queue_terms;
  wire [7:0] mask_wdata_low;
  wire [7:0] mask_wdata_high;

  assign bypass_all = {deb_high_q, deb_low_q};
  assign level_all = {level_high_q, level_low_q};
  assign mode_all = {mode_high_q, mode_low_q};
  assign oe_all = {oe_high_q, oe_low_q};
  assign mask_wdata_low = reg_wdata_in & `MASK_LOW; // [R12]
  assign mask_wdata_high = reg_wdata_in & `MASK_HIGH; // [R12]

  ////////////////////////////////////////////////////////////////////////////
  // Register writes.
  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      deb_low_q <= `REG_RESET_LOW;
      deb_high_q <= `REG_RESET_HIGH;
      level_low_q <= `REG_RESET_LOW;
      level_high_q <= `REG_RESET_HIGH;
      mode_low_q <= `REG_RESET_LOW;
      mode_high_q <= `REG_RESET_HIGH;
      oe_low_q <= `REG_RESET_LOW;
      oe_high_q <= `REG_RESET_HIGH;
      polarity_high_q <= `REG_RESET_HIGH;
      queue_en_high_q <= `REG_RESET_HIGH;
      irq_en_high_q <= `REG_RESET_HIGH;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        `ADDR_DEB_LOW: begin
          deb_low_q <= mask_wdata_low[5:0]; // [R3]
        end
        `ADDR_DEB_HIGH: begin
          deb_high_q <= mask_wdata_high[4:0]; // [R4]
        end
        `ADDR_LEVEL_LOW: begin
          level_low_q <= mask_wdata_low[5:0]; // [R5]
        end
        `ADDR_LEVEL_HIGH: begin
          level_high_q <= mask_wdata_high[4:0]; // [R6]
        end
        `ADDR_MODE_LOW: begin
          mode_low_q <= mask_wdata_low[5:0]; // [R7]
        end
        `ADDR_MODE_HIGH: begin
          mode_high_q <= mask_wdata_high[4:0]; // [R8]
        end
        `ADDR_OE_LOW: begin
          oe_low_q <= mask_wdata_low[5:0]; // [R9]
        end
        `ADDR_OE_HIGH: begin
          oe_high_q <= mask_wdata_high[4:0];
        end
        `ADDR_POLARITY_HIGH: begin
          polarity_high_q <= mask_wdata_high[4:0];
        end
        `ADDR_QUEUE_EN_HIGH: begin
          queue_en_high_q <= mask_wdata_high[4:0];
        end
        `ADDR_IRQ_EN_HIGH: begin
          irq_en_high_q <= mask_wdata_high[4:0];
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser, two flip-flops deep.
  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      sync1_q <= 11'h000;
      sync2_q <= 11'h000;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-pin debounce and driver.
  genvar i;
  generate
    for (i = 0; i < `PIN_COUNT; i = i + 1) begin : g_pin
      gpio_input_filter #(
        .CYCLES(DEBOUNCE_CYCLES),
        .CNT_W(DEBOUNCE_CNT_W)
      ) u_filter (
        .ref_clk_in(ref_clk_in),
        .sys_rst_in(sys_rst_in),
        .raw_in(sync2_q[i]),
        .bypass_in(bypass_all[i]), // [R3] [R4]
        .level_out(filt_w[i])
      );

      // Open drain never drives high; it releases the pin instead.
      always @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
          pin_out_q[i] <= 1'b0;
          pin_oe_q[i] <= 1'b0;
        end else begin
          pin_out_q[i] <= level_all[i] & ~mode_all[i]; // [R5] [R6] [R7] [R8]
          pin_oe_q[i] <= oe_all[i] & (~mode_all[i] | ~level_all[i]); // [R9] [R13]
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Upper input flags and queue reports.
  generate
    for (i = 0; i < `HIGH_PIN_COUNT; i = i + 1) begin : g_high
      assign cond_high[i] = (filt_w[`LOW_PIN_COUNT + i] == polarity_high_q[i]); // [R10]
      assign flag_set[i] = cond_high[i] & ~queue_en_high_q[i]; // [R10] [R11]
      assign flag_clr[i] = reg_wr_in & (reg_addr_in == `ADDR_FLAG_HIGH) & reg_wdata_in[i];
      assign summary_terms[i] = irq_en_high_q[i] & flag_high_q[i] & cond_high[i] & ~queue_en_high_q[i]; // [R1] [R2] [R11]
      assign queue_terms[i] = queue_en_high_q[i] & (filt_w[`LOW_PIN_COUNT + i] ^ filt_prev_q[i]); // [R11]
    end
  endgenerate

  // A set in the same cycle as a clear keeps the flag.
  always @* begin
    flag_high_d = flag_set | (flag_high_q & ~flag_clr);
  end

  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      flag_high_q <= 5'h00;
      filt_prev_q <= 5'h00;
      summary_q <= 1'b0;
      queue_event_q <= 5'h00;
      event_irq_q <= 1'b0;
      pin_level_q <= 11'h000;
    end else begin
      flag_high_q <= flag_high_d; // [R10]
      filt_prev_q <= filt_w[10:6];
      summary_q <= |summary_terms; // [R1] [R2]
      queue_event_q <= queue_terms; // [R11]
      event_irq_q <= |queue_terms; // [R11]
      pin_level_q <= filt_w;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads, answered one cycle after the strobe.
  always @* begin
    rdata_d = `READ_UNMAPPED;
    case (reg_addr_in)
      `ADDR_STATUS: begin
        rdata_d[`STATUS_SUMMARY_BIT] = summary_q; // [R1]
      end
      `ADDR_FLAG_HIGH: begin
        rdata_d[4:0] = flag_high_q;
      end
      `ADDR_POLARITY_HIGH: begin
        rdata_d[4:0] = polarity_high_q;
      end
      `ADDR_QUEUE_EN_HIGH: begin
        rdata_d[4:0] = queue_en_high_q;
      end
      `ADDR_IRQ_EN_HIGH: begin
        rdata_d[4:0] = irq_en_high_q;
      end
      `ADDR_DEB_LOW: begin
        rdata_d[5:0] = deb_low_q; // [R12]
      end
      `ADDR_DEB_HIGH: begin
        rdata_d[4:0] = deb_high_q; // [R12]
      end
      `ADDR_LEVEL_LOW: begin
        rdata_d[5:0] = level_low_q;
      end
      `ADDR_LEVEL_HIGH: begin
        rdata_d[4:0] = level_high_q;
      end
      `ADDR_MODE_LOW: begin
        rdata_d[5:0] = mode_low_q;
      end
      `ADDR_MODE_HIGH: begin
        rdata_d[4:0] = mode_high_q;
      end
      `ADDR_OE_LOW: begin
        rdata_d[5:0] = oe_low_q;
      end
      `ADDR_OE_HIGH: begin
        rdata_d[4:0] = oe_high_q;
      end
      default: begin
        rdata_d = `READ_UNMAPPED;
      end
    endcase
  end

  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= reg_rd_in;
      if (reg_rd_in) begin
        rdata_q <= rdata_d;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.
  assign reg_rdata_out = rdata_q;
  assign reg_rvalid_out = rvalid_q;
  assign pin_out = pin_out_q;
  assign pin_oe_out = pin_oe_q;
  assign pin_level_out = pin_level_q;
  assign input_irq_summary_out = summary_q;
  assign queue_event_out = queue_event_q;
  assign event_irq_out = event_irq_q;

endmodule

/* bench/gpio_pin_config_bank_checker.sv */
`timescale 1ns/10ps
module gpio_pin_config_bank_checker (
  // Clock and reset.
  input wire ref_clk_in,
  input wire sys_rst_in,
  // Register port.
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [7:0] reg_rdata_out,
  input wire reg_rvalid_out,
  // Pins and indications.
  input wire [10:0] pin_out,
  input wire [10:0] pin_oe_out,
  input wire [10:0] pin_level_out,
  input wire input_irq_summary_out,
  input wire [4:0] queue_event_out,
  input wire event_irq_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  property p_rsv;
    reg_rd_in |=> reg_rvalid_out && reg_rdata_out[7:6] == 2'b00;
  endproperty
  a_rsv: assert property (p_rsv) else $error("read reply bad");
  property p_unmap;
    reg_rd_in && reg_addr_in > 8'h28 |=> reg_rdata_out == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_lvl;
    reg_wr_in && reg_addr_in == 8'h23 |-> ##2 (pin_out[5:0] & ~$past(reg_wdata_in[5:0], 2)) == 6'h00;
  endproperty
  a_lvl: assert property (p_lvl) else $error("pin high with level low");
  property p_od;
    reg_wr_in && reg_addr_in == 8'h25 |-> ##2 (pin_out[5:0] & $past(reg_wdata_in[5:0], 2)) == 6'h00;
  endproperty
  a_od: assert property (p_od) else $error("open drain drove high");
  property p_od_high;
    reg_wr_in && reg_addr_in == 8'h26 |-> ##2 (pin_out[10:6] & $past(reg_wdata_in[4:0], 2)) == 5'h00;
  endproperty
  a_od_high: assert property (p_od_high) else $error("open drain drove high");
  property p_oe;
    reg_wr_in && reg_addr_in == 8'h27 |-> ##2 (pin_oe_out[5:0] & ~$past(reg_wdata_in[5:0], 2)) == 6'h00;
  endproperty
  a_oe: assert property (p_oe) else $error("driver on while disabled");
  property p_irq_off;
    reg_wr_in && reg_addr_in == 8'h20 && reg_wdata_in[4:0] == 5'h00 |-> ##2 !input_irq_summary_out;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("summary with enables off");
  property p_evt;
    event_irq_out == (|queue_event_out);
  endproperty
  a_evt: assert property (p_evt) else $error("event irq mismatch");
  property p_evt_edge;
    queue_event_out != 5'h00 |->
      (queue_event_out & ~(pin_level_out[10:6] ^ $past(pin_level_out[10:6]))) == 5'h00;
  endproperty
  a_evt_edge: assert property (p_evt_edge) else $error("queue event without level change");
endmodule
bind gpio_pin_config_bank gpio_pin_config_bank_checker u_chk (.ref_clk_in, .sys_rst_in, .reg_addr_in,
  .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .reg_rvalid_out, .pin_out, .pin_oe_out,
  .pin_level_out, .input_irq_summary_out, .queue_event_out, .event_irq_out);

/* bench/pin_pad_model.sv */
`timescale 1ns/10ps
module pin_pad_model (
  // Device side.
  input wire [10:0] dev_level_in,
  input wire [10:0] dev_oe_in,
  // Outside driver.
  input wire [10:0] ext_en_in,
  input wire [10:0] ext_val_in,
  // Resolved pad level.
  output wire [10:0] pad_out
);
  // A released pin reads low while the outside driver pulls it low, otherwise its pull-up level.
  assign pad_out = (dev_oe_in & dev_level_in) | (~dev_oe_in & ~(ext_en_in & ~ext_val_in));
endmodule

/* bench/tb_top.sv */
`timescale 1ns/10ps
`define CHK(n, e, a) begin compares++; if ((e) !== (a)) begin mismatches++; $display("MISMATCH %s exp %h got %h", n, e, a); end end
module tb_top;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [7:0] addr = 8'h00;
  reg [7:0] wdata = 8'h00;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg [10:0] ext_en = 11'h7ff;
  reg [10:0] ext_val = 11'h000;
  reg [10:0] lv, md, en;
  reg [7:0] d, ex;
  reg seen;
  wire [7:0] rdata;
  wire rvalid, sum, evt;
  wire [10:0] pad, pout, poe, plev;
  wire [4:0] qev;
  int mismatches = 0;
  int compares = 0;
  int seed = 32'h642fb448;
  int i;
  logic [7:0] exp_q[$];
  always #2 clk = ~clk;
  gpio_pin_config_bank #(.DEBOUNCE_CYCLES(2)) DUT (.ref_clk_in(clk), .sys_rst_in(rst), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
    .pin_in(pad), .pin_out(pout), .pin_oe_out(poe), .pin_level_out(plev), .input_irq_summary_out(sum),
    .queue_event_out(qev), .event_irq_out(evt));
  pin_pad_model pads (.dev_level_in(pout), .dev_oe_in(poe), .ext_en_in(ext_en), .ext_val_in(ext_val),
    .pad_out(pad));
  ////////////////////////////////////////////////////////////////////////////////
  task wr_reg(input [7:0] a, input [7:0] v);
    @(negedge clk);
    addr = a;
    wdata = v;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task rd_reg(input [7:0] a, input [7:0] e);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    exp_q.push_back(e);
    @(negedge clk);
    rd = 1'b0;
  endtask
  task wr_pair(input [7:0] a, input [10:0] v);
    wr_reg(a, {2'b00, v[5:0]});
    wr_reg(a + 8'h01, {3'b000, v[10:6]});
  endtask
  task final_report;
    if (exp_q.size() != 0) begin
      mismatches++;
    end
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // The read monitor compares each reply with the oldest expectation.
  always @(negedge clk) begin
    if (rvalid === 1'b1) begin
      ex = (exp_q.size() != 0) ? exp_q.pop_front() : 8'hxx;
      `CHK("rdata", ex, rdata)
    end
  end
  initial begin
    #20000;
    mismatches++;
    final_report;
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    for (i = 8'h20; i <= 8'h28; i++) begin
      rd_reg(i[7:0], 8'h00);
    end
    wr_reg(8'h01, 8'hff);
    wr_reg(8'h7f, 8'hff);
    rd_reg(8'h01, 8'h00);
    rd_reg(8'h7f, 8'h00);
    for (i = 8'h20; i <= 8'h28; i++) begin
      d = 8'($random(seed));
      wr_reg(i[7:0], d);
      rd_reg(i[7:0], d & (i[0] ? 8'h3f : 8'h1f));
    end
    $display("test registers done");
    repeat (4) begin
      lv = 11'($random(seed));
      md = 11'($random(seed));
      en = 11'($random(seed));
      wr_pair(8'h23, lv);
      wr_pair(8'h25, md);
      wr_pair(8'h27, en);
      repeat (2) @(negedge clk);
      `CHK("pin_oe", en & (~md | ~lv), poe)
      `CHK("pin_out", lv & ~md & en, pout & poe)
    end
    $display("test drive done");
    wr_pair(8'h27, 11'h000);
    wr_reg(8'h20, 8'h00);
    wr_reg(8'h22, 8'h1f);
    wr_reg(8'h1c, 8'h01);
    wr_reg(8'h1e, 8'h00);
    wr_reg(8'h14, 8'h1f);
    wr_reg(8'h20, 8'h01);
    repeat (8) @(negedge clk);
    `CHK("summary idle", 1'b0, sum)
    ext_val[6] = 1'b1;
    for (i = 0; i < 20 && sum !== 1'b1; i++) @(negedge clk);
    `CHK("summary set", 1'b1, sum)
    rd_reg(8'h14, 8'h1f);
    wr_reg(8'h20, 8'h00);
    repeat (2) @(negedge clk);
    `CHK("summary off", 1'b0, sum)
    wr_reg(8'h1e, 8'h01);
    wr_reg(8'h20, 8'h01);
    repeat (4) @(negedge clk);
    `CHK("summary queued", 1'b0, sum)
    ext_val[6] = 1'b0;
    for (i = 0; i < 20 && evt !== 1'b1; i++) @(negedge clk);
    `CHK("event", 1'b1, evt)
    `CHK("queue", 5'h01, qev)
    $display("test interrupts done");
    wr_reg(8'h21, 8'h00);
    ext_val[1] = 1'b1;
    @(negedge clk);
    ext_val[1] = 1'b0;
    seen = 1'b0;
    repeat (8) begin
      @(negedge clk);
      seen = seen | plev[1];
    end
    `CHK("glitch", 1'b0, seen)
    wr_reg(8'h21, 8'h02);
    ext_val[1] = 1'b1;
    repeat (4) @(negedge clk);
    `CHK("bypass", 1'b1, plev[1])
    $display("test debounce done");
    wr_reg(8'h25, 8'h00);
    wr_reg(8'h27, 8'h3f);
    repeat (2) @(negedge clk);
    `CHK("oe set", 11'h03f, poe)
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    `CHK("oe reset", 11'h000, poe)
    rd_reg(8'h21, 8'h00);
    rd_reg(8'h27, 8'h00);
    repeat (2) @(negedge clk);
    $display("test reset done");
    final_report;
  end
endmodule
